// ### iox_consts.vh
// Constants for the four-bit I2C port expander
`ifndef IOX_CONSTS_VH
`define IOX_CONSTS_VH
// Target address, seven bits
`define IOX_TARGET_ADDR 7'h41
// Register selection codes
`define IOX_SEL_INPUT 2'h0
`define IOX_SEL_OUTPUT 2'h1
`define IOX_SEL_POLARITY 2'h2
`define IOX_SEL_CONFIG 2'h3
// Reset values
`define IOX_RST_OUTPUT 4'hF
`define IOX_RST_POLARITY 4'h0
`define IOX_RST_CONFIG 4'hF
// Unused upper nibble reads as ones, except in the polarity register where it reads as zeros
`define IOX_UNUSED_HI 4'hF
// Bits per byte
`define IOX_BYTE_BITS 4'h8
// Write data FIFO shape
`define IOX_FIFO_WIDTH 8
`define IOX_FIFO_DEPTH 16
`define IOX_FIFO_AW 4
`endif

// ### iox_fifo.v
// Holds no logic: the write-data FIFO module sits beside the expander logic

// ### iox_expander.v
// Four-bit I2C port expander: bus target, registers and port drivers
`timescale 1ns/10ps
`include "iox_consts.vh"
// Summary of operation
// R01: Pins come up as inputs after reset
// R02: Pin direction follows configuration bit
// R03: Input bits optionally inverted by polarity
// R04: Input pin: drivers off, weak pullup
// R05: Output pin driven from output register
// R06: Reset loads defaults into registers, bus
// R07: Always accept requests, track input pins
// R08: Controller starts only on idle bus
// R09: SDA falling, SCL high is start
// R10: Address shifted in MSB first, R/W last
// R11: Matching address acknowledged low ninth clock
// R12: One bit per pulse; high-phase changes control
// R13: SDA rising, SCL high is stop
// R14: Any byte count, eight bits plus ack
// R15: Transmitter releases SDA before ack clock
// R16: Every received byte acknowledged
// R17: Controller NACK ends read; device releases SDA
// R18: Respond only to address 0x41
// R19: Command byte low bits select register
// R20: Config one input, zero output
module iox_expander (
    input wire core_clk,
    input wire rstn,
    input wire scl_in,
    input wire sda_in,
    output reg sda_out,
    output reg sda_oe,
    input wire [3:0] port_pins_in,
    output reg [3:0] port_pins_out,
    output reg [3:0] port_pins_oe,
    output reg busy
);
    // ==========================================
    // States
    localparam ST_IDLE = 3'h0;
    localparam ST_ADDR = 3'h1;
    localparam ST_AACK = 3'h2;
    localparam ST_WBYTE = 3'h3;
    localparam ST_WACK = 3'h4;
    localparam ST_RBYTE = 3'h5;
    localparam ST_RACK = 3'h6;

    // Register read mux
    function [7:0] reg_view;
        input [1:0] sel;
        input [3:0] inp;
        input [3:0] outp;
        input [3:0] pol;
        input [3:0] cfg;
        begin
            case (sel)
                `IOX_SEL_INPUT: reg_view = {`IOX_UNUSED_HI, inp ^ pol}; // [R03]
                `IOX_SEL_OUTPUT: reg_view = {`IOX_UNUSED_HI, outp};
                `IOX_SEL_POLARITY: reg_view = {4'h0, pol};
                default: reg_view = {`IOX_UNUSED_HI, cfg};
            endcase
        end
    endfunction

    // ==========================================
    // Input synchronisers
    reg scl_s1_reg, scl_s2_reg, scl_d_reg;
    reg sda_s1_reg, sda_s2_reg, sda_d_reg;
    reg [3:0] pin_s1_reg, pin_s2_reg;
    always @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            scl_s1_reg <= 1'b1;
            scl_s2_reg <= 1'b1;
            scl_d_reg <= 1'b1;
            sda_s1_reg <= 1'b1;
            sda_s2_reg <= 1'b1;
            sda_d_reg <= 1'b1;
            pin_s1_reg <= 4'hF;
            pin_s2_reg <= 4'hF;
        end else begin
            scl_s1_reg <= scl_in;
            scl_s2_reg <= scl_s1_reg;
            scl_d_reg <= scl_s2_reg;
            sda_s1_reg <= sda_in;
            sda_s2_reg <= sda_s1_reg;
            sda_d_reg <= sda_s2_reg;
            pin_s1_reg <= port_pins_in; // [R07]
            pin_s2_reg <= pin_s1_reg;
        end
    end

    // Bus event decode
    wire scl_rise = scl_s2_reg && !scl_d_reg;
    wire scl_fall = !scl_s2_reg && scl_d_reg;
    wire start_det = scl_s2_reg && scl_d_reg && sda_d_reg && !sda_s2_reg; // [R09] [R12]
    wire stop_det = scl_s2_reg && scl_d_reg && !sda_d_reg && sda_s2_reg; // [R13] [R12]

    // ==========================================
    // Registers
    reg [2:0] state_reg;
    reg [3:0] bit_cnt_reg;
    reg [7:0] shift_reg;
    reg rw_reg;
    reg cmd_seen_reg;
    reg [1:0] sel_reg;
    reg [3:0] out_reg;
    reg [3:0] pol_reg;
    reg [3:0] cfg_reg;
    reg [7:0] tx_reg;
    reg nack_reg;

    // FIFO carries received data bytes to the register writer
    wire fifo_in_ready;
    wire [7:0] fifo_out_data;
    wire fifo_out_valid;
    reg fifo_push;
    reg [7:0] fifo_push_data;
    iox_fifo #(
        .WIDTH(`IOX_FIFO_WIDTH),
        .DEPTH(`IOX_FIFO_DEPTH),
        .AW(`IOX_FIFO_AW)
    ) u_fifo (
        .core_clk(core_clk),
        .rstn(rstn),
        .in_data(fifo_push_data),
        .in_valid(fifo_push),
        .in_ready(fifo_in_ready),
        .out_data(fifo_out_data),
        .out_valid(fifo_out_valid),
        .out_ready(1'b1)
    );
    // Entries hold {sel, data nibble}; writer drains one per clock
    wire [1:0] wr_sel = fifo_out_data[5:4];
    wire [3:0] wr_val = fifo_out_data[3:0];
    // Byte offered to the controller, with the pins as sampled at load time
    wire [7:0] rd_view = reg_view(sel_reg, pin_s2_reg, out_reg, pol_reg, cfg_reg);

    // ==========================================
    // Bus target state machine
    always @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            state_reg <= ST_IDLE; // [R06]
            bit_cnt_reg <= 4'h0;
            shift_reg <= 8'h00;
            rw_reg <= 1'b0;
            cmd_seen_reg <= 1'b0;
            sel_reg <= `IOX_SEL_INPUT;
            tx_reg <= 8'h00;
            nack_reg <= 1'b0;
            sda_out <= 1'b0;
            sda_oe <= 1'b0;
            busy <= 1'b0;
            fifo_push <= 1'b0;
            fifo_push_data <= 8'h00;
        end else begin
            fifo_push <= 1'b0;
            if (start_det) begin
                // Start or repeated start; restart keeps sel_reg
                state_reg <= ST_ADDR;
                bit_cnt_reg <= 4'h0;
                sda_oe <= 1'b0;
                busy <= 1'b1;
            end else if (stop_det) begin
                state_reg <= ST_IDLE;
                sda_oe <= 1'b0;
                busy <= 1'b0;
            end else begin
                case (state_reg)
                    ST_IDLE: begin
                        sda_oe <= 1'b0;
                    end
                    ST_ADDR, ST_WBYTE: begin
                        if (scl_rise) begin
                            shift_reg <= {shift_reg[6:0], sda_s2_reg}; // [R10]
                            bit_cnt_reg <= bit_cnt_reg + 4'h1;
                        end else if (scl_fall && bit_cnt_reg == `IOX_BYTE_BITS) begin // [R14]
                            bit_cnt_reg <= 4'h0;
                            if (state_reg == ST_ADDR) begin
                                if (shift_reg[7:1] == `IOX_TARGET_ADDR) begin // [R18]
                                    rw_reg <= shift_reg[0];
                                    cmd_seen_reg <= 1'b0;
                                    sda_out <= 1'b0; // [R11]
                                    sda_oe <= 1'b1;
                                    state_reg <= ST_AACK;
                                end else begin
                                    state_reg <= ST_IDLE;
                                    busy <= 1'b0;
                                end
                            end else begin
                                if (!cmd_seen_reg) begin
                                    sel_reg <= shift_reg[1:0]; // [R19]
                                    cmd_seen_reg <= 1'b1;
                                end else if (fifo_in_ready) begin
                                    fifo_push <= 1'b1;
                                    fifo_push_data <= {2'h0, sel_reg, shift_reg[3:0]};
                                end
                                sda_out <= 1'b0; // [R16]
                                sda_oe <= 1'b1;
                                state_reg <= ST_WACK;
                            end
                        end
                    end
                    ST_AACK, ST_WACK: begin
                        if (scl_fall) begin
                            if (state_reg == ST_AACK && rw_reg) begin
                                // First read byte loaded as ack ends
                                tx_reg <= rd_view;
                                sda_out <= rd_view[7];
                                sda_oe <= ~rd_view[7];
                                bit_cnt_reg <= 4'h0;
                                state_reg <= ST_RBYTE;
                            end else begin
                                sda_oe <= 1'b0; // [R15]
                                state_reg <= ST_WBYTE;
                            end
                        end
                    end
                    ST_RBYTE: begin
                        if (scl_fall) begin
                            if (bit_cnt_reg == `IOX_BYTE_BITS - 4'h1) begin
                                sda_oe <= 1'b0; // [R15]
                                bit_cnt_reg <= 4'h0;
                                state_reg <= ST_RACK;
                            end else begin
                                tx_reg <= {tx_reg[6:0], 1'b0};
                                sda_out <= tx_reg[6];
                                sda_oe <= ~tx_reg[6]; // Open-drain: drive only lows
                                bit_cnt_reg <= bit_cnt_reg + 4'h1;
                            end
                        end
                    end
                    ST_RACK: begin
                        if (scl_rise) begin
                            nack_reg <= sda_s2_reg;
                        end else if (scl_fall) begin
                            if (nack_reg) begin
                                sda_oe <= 1'b0; // [R17]
                                state_reg <= ST_IDLE;
                            end else begin
                                tx_reg <= rd_view; // [R07]
                                sda_out <= rd_view[7];
                                sda_oe <= ~rd_view[7];
                                state_reg <= ST_RBYTE;
                            end
                        end
                    end
                    default: begin
                        state_reg <= ST_IDLE;
                        sda_oe <= 1'b0;
                    end
                endcase
            end
        end
    end

    // ==========================================
    // Register writer draining the FIFO
    always @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            out_reg <= `IOX_RST_OUTPUT; // [R06]
            pol_reg <= `IOX_RST_POLARITY;
            cfg_reg <= `IOX_RST_CONFIG; // [R01]
        end else if (fifo_out_valid) begin
            case (wr_sel)
                `IOX_SEL_OUTPUT: out_reg <= wr_val;
                `IOX_SEL_POLARITY: pol_reg <= wr_val;
                `IOX_SEL_CONFIG: cfg_reg <= wr_val; // [R02]
                default: out_reg <= out_reg; // Input register ignores writes
            endcase
        end
    end

    // ==========================================
    // Port pin drivers
    always @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            port_pins_out <= `IOX_RST_OUTPUT;
            port_pins_oe <= 4'h0; // [R01]
        end else begin
            port_pins_out <= out_reg; // [R05]
            port_pins_oe <= ~cfg_reg; // [R20] [R04]
        end
    end
endmodule // iox_expander

// Write-data FIFO with valid/ready on both sides
module iox_fifo #(
    parameter WIDTH = 8,
    parameter DEPTH = 16,
    parameter AW = 4
) (
    input wire core_clk,
    input wire rstn,
    input wire [WIDTH-1:0] in_data,
    input wire in_valid,
    output wire in_ready,
    output wire [WIDTH-1:0] out_data,
    output wire out_valid,
    input wire out_ready
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW:0] wr_ptr_reg;
    reg [AW:0] rd_ptr_reg;
    wire [AW:0] fill;
    assign fill = wr_ptr_reg - rd_ptr_reg;
    assign in_ready = (fill != DEPTH[AW:0]);
    assign out_valid = (fill != {(AW+1){1'b0}});
    assign out_data = mem[rd_ptr_reg[AW-1:0]];
    // ==========================================
    // Pointer and storage update
    always @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            wr_ptr_reg <= {(AW+1){1'b0}};
            rd_ptr_reg <= {(AW+1){1'b0}};
        end else begin
            if (in_valid && in_ready) begin
                wr_ptr_reg <= wr_ptr_reg + 1'b1;
            end
            if (out_valid && out_ready) begin
                rd_ptr_reg <= rd_ptr_reg + 1'b1;
            end
        end
    end
    // Storage has no reset
    always @(posedge core_clk) begin
        if (in_valid && in_ready) begin
            mem[wr_ptr_reg[AW-1:0]] <= in_data;
        end
    end
endmodule // iox_fifo

// ### iox_expander_asserts.sv
// Concurrent checks on the port expander's pins
`timescale 1ns/10ps
module iox_expander_asserts (
    input wire core_clk,
    input wire rstn,
    input wire scl_in,
    input wire sda_in,
    input wire sda_out,
    input wire sda_oe,
    input wire [3:0] port_pins_in,
    input wire [3:0] port_pins_out,
    input wire [3:0] port_pins_oe,
    input wire busy
);
    // ==========================================================
    // Bus and port checks
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rstn);
    a_sda_open_drain: assert property (sda_oe |-> !sda_out)
        else $error("sda driven high");
    a_sda_high_stable: assert property (scl_in && $past(scl_in) |-> $stable(sda_oe))
        else $error("sda drive changed while scl high");
    a_ack_hold: assert property ($fell(scl_in) && sda_oe |=> sda_oe)
        else $error("sda drive dropped at scl fall");
    a_idle_quiet: assert property (!busy && !$past(busy) |-> !sda_oe)
        else $error("sda driven while idle");
    a_pins_reset: assert property ($rose(rstn) |-> port_pins_oe == 4'h0)
        else $error("pins driven after reset");
    a_dir_on_bus: assert property ($changed(port_pins_oe) |-> busy || $past(busy))
        else $error("pin direction changed without bus write");
    a_out_on_bus: assert property ($changed(port_pins_out) |-> busy || $past(busy))
        else $error("pin output changed without bus write");
    a_start_busy: assert property ($fell(sda_in) && scl_in |-> ##[1:5] busy)
        else $error("start not detected");
    a_stop_idle: assert property ($rose(sda_in) && scl_in |-> ##[1:5] !busy)
        else $error("stop not detected");
endmodule // iox_expander_asserts

bind iox_expander iox_expander_asserts iox_expander_asserts_inst (
    .core_clk(core_clk), .rstn(rstn), .scl_in(scl_in), .sda_in(sda_in),
    .sda_out(sda_out), .sda_oe(sda_oe), .port_pins_in(port_pins_in),
    .port_pins_out(port_pins_out), .port_pins_oe(port_pins_oe), .busy(busy));

// ### iox_ctrl_model.sv
// Bus controller model driving SCL and pulling SDA low
`timescale 1ns/10ps
module iox_ctrl_model (
    input wire core_clk,
    input wire sda,
    output reg scl,
    output reg sda_low
);
    // ==========================================================
    // Bus idle at time zero, both lines released
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end
    task q(input integer n);
        repeat (n) @(negedge core_clk);
    endtask
    // One bit: set SDA in low phase, sample mid high phase
    task bit_io(input b, output r);
        begin
            sda_low = ~b;
            q(2);
            scl = 1'b1;
            q(2);
            r = sda;
            q(2);
            scl = 1'b0;
            q(2);
        end
    endtask
    // Start or repeated start
    task start;
        begin
            sda_low = 1'b0;
            q(2);
            scl = 1'b1;
            q(4);
            sda_low = 1'b1;
            q(4);
            scl = 1'b0;
            q(2);
        end
    endtask
    task stop;
        begin
            sda_low = 1'b1;
            q(2);
            scl = 1'b1;
            q(4);
            sda_low = 1'b0;
            q(4);
        end
    endtask
    // Eight bits MSB first then the acknowledge bit
    task xfer(input [7:0] d, input a_in, output [7:0] r, output a);
        integer i;
        reg b;
        begin
            for (i = 7; i >= 0; i = i - 1) begin
                bit_io(d[i], b);
                r[i] = b;
            end
            bit_io(a_in, a);
        end
    endtask
endmodule // iox_ctrl_model

// ### iox_expander_tb.sv
// Self-checking bench for the four-bit port expander
`timescale 1ns/10ps
`include "iox_consts.vh"
module iox_expander_tb;
    reg core_clk = 1'b0;
    reg rstn = 1'b0;
    reg [3:0] ext_val = 4'h0;
    reg [3:0] ext_en = 4'h0;
    reg [7:0] rd;
    reg ack;
    integer error_cnt = 0;
    integer num_checks = 0;
    wire scl, sda_low, sda_out, sda_oe, busy;
    wire [3:0] pins_out, pins_oe;
    // Open-drain SDA with pull-up; pins weakly pulled up when undriven
    wire sda = ~(sda_low | (sda_oe & ~sda_out));
    wire [3:0] pins = (pins_oe & pins_out) | (~pins_oe & ((ext_en & ext_val) | ~ext_en));
    always #50 core_clk = ~core_clk;
    iox_ctrl_model iox_ctrl_model_inst (.core_clk(core_clk), .sda(sda), .scl(scl),
        .sda_low(sda_low));
    iox_expander iox_expander_inst (.core_clk(core_clk), .rstn(rstn), .scl_in(scl),
        .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe), .port_pins_in(pins),
        .port_pins_out(pins_out), .port_pins_oe(pins_oe), .busy(busy));
    // ==========================================================
    // Access tasks
    task chk(input [8*10:1] name, input [7:0] seen, input [7:0] exp);
        begin
            num_checks = num_checks + 1;
            if (seen !== exp) begin
                $display("wrong value %0s expected %h seen %h", name, exp, seen);
                error_cnt = error_cnt + 1;
            end
        end
    endtask
    task addr(input rw, input [6:0] a, input exp_ack);
        begin
            iox_ctrl_model_inst.start;
            iox_ctrl_model_inst.xfer({a, rw}, 1'b1, rd, ack);
            chk("addr ack", {7'h00, ack}, {7'h00, exp_ack});
        end
    endtask
    task send(input [7:0] d);
        begin
            iox_ctrl_model_inst.xfer(d, 1'b1, rd, ack);
            chk("write ack", {7'h00, ack}, 8'h00);
        end
    endtask
    task wr(input [1:0] sel, input [7:0] d);
        begin
            addr(1'b0, `IOX_TARGET_ADDR, 1'b0);
            send({6'h00, sel});
            send(d);
            iox_ctrl_model_inst.stop;
        end
    endtask
    task rd_reg(input [1:0] sel, input [7:0] exp);
        begin
            addr(1'b0, `IOX_TARGET_ADDR, 1'b0);
            send({6'h00, sel});
            addr(1'b1, `IOX_TARGET_ADDR, 1'b0);
            iox_ctrl_model_inst.xfer(8'hFF, 1'b1, rd, ack);
            chk("read data", rd, exp);
            iox_ctrl_model_inst.stop;
        end
    endtask
    task finish_test;
        begin
            if (error_cnt == 0 && num_checks > 0)
                $display("*** PASS ***");
            else
                $display("*** FAIL ***");
            $finish;
        end
    endtask
    // Watchdog on the whole run
    initial begin
        repeat (100000) @(posedge core_clk);
        error_cnt = error_cnt + 1;
        finish_test;
    end
    // ==========================================================
    // Main sequence
    initial begin
        repeat (3) @(negedge core_clk);
        rstn = 1'b1;
        repeat (3) @(negedge core_clk);
        chk("pins oe", {4'h0, pins_oe}, 8'h00);
        chk("pins out", {4'h0, pins_out}, 8'h0F);
        rd_reg(`IOX_SEL_OUTPUT, 8'hFF);
        rd_reg(`IOX_SEL_POLARITY, 8'h00);
        rd_reg(`IOX_SEL_CONFIG, 8'hFF);
        ext_en = 4'hF;
        ext_val = 4'h6;
        rd_reg(`IOX_SEL_INPUT, 8'hF6);
        wr(`IOX_SEL_OUTPUT, 8'h0A);
        chk("pins oe", {4'h0, pins_oe}, 8'h00);
        wr(`IOX_SEL_CONFIG, 8'h0C);
        ext_en = 4'hC;
        chk("pins oe", {4'h0, pins_oe}, 8'h03);
        chk("pins out", {4'h0, pins_out}, 8'h0A);
        // Two data bytes in one write land on the same register
        addr(1'b0, `IOX_TARGET_ADDR, 1'b0);
        chk("busy", {7'h00, busy}, 8'h01);
        send({6'h00, `IOX_SEL_POLARITY});
        send(8'h0F);
        send(8'h08);
        iox_ctrl_model_inst.stop;
        rd_reg(`IOX_SEL_INPUT, 8'hFE);
        // Writes to the input register change nothing
        wr(`IOX_SEL_INPUT, 8'h05);
        chk("pins out", {4'h0, pins_out}, 8'h0A);
        // Acknowledged byte, then final byte left unacknowledged
        addr(1'b0, `IOX_TARGET_ADDR, 1'b0);
        send({6'h00, `IOX_SEL_CONFIG});
        addr(1'b1, `IOX_TARGET_ADDR, 1'b0);
        iox_ctrl_model_inst.xfer(8'hFF, 1'b0, rd, ack);
        chk("read ack", rd, 8'hFC);
        iox_ctrl_model_inst.xfer(8'hFF, 1'b1, rd, ack);
        chk("read nack", rd, 8'hFC);
        iox_ctrl_model_inst.stop;
        addr(1'b1, `IOX_TARGET_ADDR, 1'b0);
        iox_ctrl_model_inst.xfer(8'hFF, 1'b1, rd, ack);
        chk("kept sel", rd, 8'hFC);
        iox_ctrl_model_inst.stop;
        addr(1'b0, 7'h40, 1'b1);
        chk("busy", {7'h00, busy}, 8'h00);
        iox_ctrl_model_inst.stop;
        wr(`IOX_SEL_CONFIG, 8'h00);
        chk("pins oe", {4'h0, pins_oe}, 8'h0F);
        chk("pins", {4'h0, pins}, 8'h0A);
        // Reset in mid-run restores defaults
        rstn = 1'b0;
        repeat (3) @(negedge core_clk);
        rstn = 1'b1;
        repeat (3) @(negedge core_clk);
        chk("pins oe", {4'h0, pins_oe}, 8'h00);
        chk("pins out", {4'h0, pins_out}, 8'h0F);
        rd_reg(`IOX_SEL_CONFIG, 8'hFF);
        finish_test;
    end
endmodule // iox_expander_tb
